// file: logic/dspg_pkg.sv
package dspg_pkg;

	localparam int          MODE_W       = 5;
	localparam logic [4:0]  MODE_USER    = 5'h10;
	localparam logic [4:0]  MODE_FIQ     = 5'h11;
	localparam logic [4:0]  MODE_IRQ     = 5'h12;
	localparam logic [4:0]  MODE_SVC     = 5'h13;
	localparam logic [4:0]  MODE_MONITOR = 5'h16;
	localparam logic [4:0]  MODE_ABORT   = 5'h17;
	localparam logic [4:0]  MODE_UNDEF   = 5'h1B;
	localparam logic [4:0]  MODE_SYSTEM  = 5'h1F;
	localparam logic [2:0]  OPC1_DEBUG   = 3'h0;
	localparam logic        NS_SECURE    = 1'h0;
	localparam logic        STICKY_RESET = 1'h0;

	typedef enum logic [2:0] {
		OP_NONPRIV,
		OP_OTHER_PRIV,
		OP_STATUS_WRITE,
		OP_SECCFG_WRITE,
		OP_DEBUG_CP,
		OP_SYSTEM_CP,
		OP_EXTERNAL_CP,
		OP_LOAD_STORE
	} dspg_op_t;

	typedef enum logic [1:0] {
		REACH_NONSECURE,
		REACH_SECURE_ONLY,
		REACH_RESTRICTED,
		REACH_CONFIGURABLE
	} dspg_reach_t;

	typedef struct packed {
		logic                valid;
		dspg_op_t            op;
		logic [MODE_W-1:0]   new_mode;
		logic                user_ok;
		logic                priv_ok;
		logic [2:0]          opc1;
		logic                coherency;
		logic                lock_affected;
		dspg_reach_t         reach;
		logic                ns_configured;
		logic                monitor_only;
		logic                unpriv_ldst;
	} dspg_req_t;

	typedef struct packed {
		logic                valid;
		logic                execute;
		logic                undefined;
		logic                discard;
		logic                priv_access;
		logic                bank_nonsecure;
		logic [MODE_W-1:0]   bank_mode;
		logic                mode_we;
		logic                priv_bits_we;
		logic                fiq_mask_we;
		logic                abort_mask_we;
	} dspg_verdict_t;

endpackage : dspg_pkg

// file: logic/dspg_mode_decode.sv
module dspg_mode_decode (
	input  wire logic [4:0] mode_i,
	input  wire logic       nonsecure_state_bit_i,
	output logic            is_user_o,
	output logic            is_monitor_o,
	output logic            is_privileged_o,
	output logic            is_legal_o,
	output logic            secure_world_o
);

	assign is_user_o    = (mode_i == dspg_pkg::MODE_USER);
	assign is_monitor_o = (mode_i == dspg_pkg::MODE_MONITOR);
	assign is_legal_o   = is_user_o || is_monitor_o
		|| (mode_i == dspg_pkg::MODE_FIQ) || (mode_i == dspg_pkg::MODE_IRQ)
		|| (mode_i == dspg_pkg::MODE_SVC) || (mode_i == dspg_pkg::MODE_ABORT)
		|| (mode_i == dspg_pkg::MODE_UNDEF) || (mode_i == dspg_pkg::MODE_SYSTEM);
	assign is_privileged_o = is_legal_o && !is_user_o;
	// Monitor mode is always secure, whatever the world bit says.
	assign secure_world_o  = (nonsecure_state_bit_i == dspg_pkg::NS_SECURE) || is_monitor_o;

endmodule : dspg_mode_decode

// file: logic/dspg_gate.sv
module dspg_gate #(
	parameter bit HAS_SECURITY = 1'b1
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire logic                  debug_state_i,
	input  wire logic [4:0]            current_mode_i,
	input  wire logic                  nonsecure_state_bit_i,
	input  wire logic                  invasive_debug_enable_i,
	input  wire logic                  secure_privileged_debug_enable_i,
	input  wire logic                  secure_sysctrl_lock_i,
	input  wire logic                  fiq_mask_writable_i,
	input  wire logic                  abort_mask_writable_i,
	input  wire dspg_pkg::dspg_req_t   req_i,
	input  wire logic                  sticky_undef_clear_i,
	output dspg_pkg::dspg_verdict_t    verdict_o,
	output logic                       sticky_undef_o
);

	logic cur_user;
	logic cur_monitor;
	logic cur_priv;
	logic cur_secure;
	logic tgt_monitor;
	logic tgt_priv;
	logic tgt_legal;
	logic tgt_secure;

	dspg_mode_decode u_cur_decode (
		.mode_i                (current_mode_i),
		.nonsecure_state_bit_i (nonsecure_state_bit_i),
		.is_user_o             (cur_user),
		.is_monitor_o          (cur_monitor),
		.is_privileged_o       (cur_priv),
		.is_legal_o            (),
		.secure_world_o        (cur_secure)
	);

	dspg_mode_decode u_tgt_decode (
		.mode_i                (req_i.new_mode),
		.nonsecure_state_bit_i (nonsecure_state_bit_i),
		.is_user_o             (),
		.is_monitor_o          (tgt_monitor),
		.is_privileged_o       (tgt_priv),
		.is_legal_o            (tgt_legal),
		.secure_world_o        (tgt_secure)
	);

	// Every decision is combinational on the present inputs
	wire auth_full      = invasive_debug_enable_i && secure_privileged_debug_enable_i;
	wire sec_ext        = HAS_SECURITY;
	wire in_secure      = sec_ext && cur_secure;
	wire in_nonsecure   = sec_ext && !cur_secure;
	wire user_locked    = sec_ext && in_secure && cur_user && !auth_full;
	wire check          = req_i.valid && debug_state_i;

	// Monitor may be reached only from secure privileged modes or with full auth.
	wire monitor_ok     = !sec_ext || auth_full || (in_secure && cur_priv);
	// Leaving secure user for a secure privileged mode needs full auth; nonsecure modes are not held back here.
	wire secpriv_ok     = !sec_ext || auth_full || (in_secure && cur_priv);
	wire tgt_allowed    = tgt_legal
		&& (!tgt_monitor || monitor_ok)
		&& (!(tgt_priv && tgt_secure && !tgt_monitor) || secpriv_ok || !in_secure);
	wire status_ok      = !user_locked;
	wire mode_we        = status_ok && tgt_allowed;
	wire fiq_we         = status_ok && !(in_nonsecure && fiq_mask_writable_i);
	wire abort_we       = status_ok && !(in_nonsecure && abort_mask_writable_i);

	// Secure configuration writes.
	wire seccfg_ok      = in_secure && (cur_priv || auth_full);
	wire seccfg_lock    = secure_sysctrl_lock_i && req_i.lock_affected;

	// A privileged mode switch would be permitted, so privileged access is granted.
	wire can_escalate   = !sec_ext || !user_locked;
	wire world_reach_ok = !in_nonsecure
		|| (req_i.reach == dspg_pkg::REACH_NONSECURE)
		|| ((req_i.reach == dspg_pkg::REACH_CONFIGURABLE) && req_i.ns_configured);
	wire priv_cp_ok     = can_escalate && req_i.priv_ok && !req_i.monitor_only
		&& world_reach_ok;
	wire debug_cp_ok    = req_i.user_ok
		|| ((req_i.opc1 == dspg_pkg::OPC1_DEBUG) && req_i.priv_ok)
		|| priv_cp_ok;
	wire sys_cp_ok      = !seccfg_lock
		&& (req_i.user_ok || req_i.coherency || priv_cp_ok);

	dspg_pkg::dspg_verdict_t verdict_next;
	dspg_pkg::dspg_verdict_t verdict_reg;
	logic                    sticky_next;
	logic                    sticky_reg;

	always_comb begin
		verdict_next                = '0;
		verdict_next.valid          = check;
		verdict_next.bank_mode      = current_mode_i;
		verdict_next.priv_access    = cur_priv;
		verdict_next.bank_nonsecure = in_nonsecure;
		case (req_i.op)
			dspg_pkg::OP_NONPRIV: begin
				verdict_next.execute = 1'b1;
			end
			dspg_pkg::OP_LOAD_STORE: begin
				verdict_next.execute     = 1'b1;
				verdict_next.priv_access = cur_priv && !req_i.unpriv_ldst;
			end
			dspg_pkg::OP_OTHER_PRIV: begin
				verdict_next.execute = !user_locked;
				verdict_next.discard = user_locked;
			end
			dspg_pkg::OP_STATUS_WRITE: begin
				// An ignored write still retires; only the guarded fields are held.
				verdict_next.execute       = 1'b1;
				verdict_next.mode_we       = mode_we;
				verdict_next.priv_bits_we  = status_ok;
				verdict_next.fiq_mask_we   = fiq_we;
				verdict_next.abort_mask_we = abort_we;
			end
			dspg_pkg::OP_SECCFG_WRITE: begin
				if (sec_ext) begin
					verdict_next.execute   = seccfg_ok && !seccfg_lock;
					verdict_next.undefined = !(seccfg_ok && !seccfg_lock);
				end else begin
					verdict_next.execute   = sys_cp_ok;
					verdict_next.undefined = !sys_cp_ok;
				end
			end
			dspg_pkg::OP_DEBUG_CP: begin
				verdict_next.execute   = debug_cp_ok;
				verdict_next.undefined = !debug_cp_ok;
			end
			dspg_pkg::OP_SYSTEM_CP: begin
				verdict_next.execute   = sys_cp_ok;
				verdict_next.undefined = !sys_cp_ok;
			end
			dspg_pkg::OP_EXTERNAL_CP: begin
				verdict_next.execute = 1'b1;
			end
			default: begin
				verdict_next.undefined = 1'b1;
			end
		endcase
		if (!check) begin
			verdict_next.execute       = 1'b0;
			verdict_next.undefined     = 1'b0;
			verdict_next.discard       = 1'b0;
			verdict_next.mode_we       = 1'b0;
			verdict_next.priv_bits_we  = 1'b0;
			verdict_next.fiq_mask_we   = 1'b0;
			verdict_next.abort_mask_we = 1'b0;
		end
	end

	// A new refusal wins over a clear arriving in the same cycle.
	wire refuse_event = verdict_next.undefined || verdict_next.discard;
	assign sticky_next = refuse_event || (sticky_reg && !sticky_undef_clear_i);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			verdict_reg <= '0;
			sticky_reg  <= dspg_pkg::STICKY_RESET;
		end else begin
			verdict_reg <= verdict_next;
			sticky_reg  <= sticky_next;
		end
	end

	assign verdict_o      = verdict_reg;
	assign sticky_undef_o = sticky_reg;

	default clocking dspg_cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence locked_priv_req;
		req_i.valid && debug_state_i && req_i.op == dspg_pkg::OP_OTHER_PRIV
			&& HAS_SECURITY && cur_secure && cur_user
			&& !(invasive_debug_enable_i && secure_privileged_debug_enable_i);
	endsequence

	sequence refused_out;
		verdict_o.valid && !verdict_o.execute;
	endsequence

	locked_discard_a: assert property (locked_priv_req |=> refused_out ##0 verdict_o.discard)
		else $error("locked privileged instruction was not discarded");

	discard_sticky_a: assert property ((verdict_o.discard || verdict_o.undefined)
		|-> sticky_undef_o)
		else $error("refusal did not set sticky flag");

	sticky_holds_a: assert property (sticky_undef_o && !$past(sticky_undef_clear_i)
		&& !$past(reset_i) |-> $past(sticky_undef_o, 1) || $past(refuse_event))
		else $error("sticky flag rose without a refusal");

	sticky_clear_a: assert property (sticky_undef_o && sticky_undef_clear_i && !refuse_event
		|=> !sticky_undef_o)
		else $error("sticky flag did not clear");

	status_ignored_a: assert property (req_i.valid && debug_state_i
		&& req_i.op == dspg_pkg::OP_STATUS_WRITE && HAS_SECURITY && cur_secure && cur_user
		&& !(invasive_debug_enable_i && secure_privileged_debug_enable_i)
		|=> !verdict_o.priv_bits_we && !verdict_o.mode_we && !verdict_o.discard)
		else $error("secure user status write was not ignored");

	monitor_block_a: assert property (req_i.valid && debug_state_i
		&& req_i.op == dspg_pkg::OP_STATUS_WRITE && HAS_SECURITY
		&& req_i.new_mode == dspg_pkg::MODE_MONITOR
		&& !(invasive_debug_enable_i && secure_privileged_debug_enable_i)
		&& (!cur_secure || cur_user) |=> !verdict_o.mode_we)
		else $error("mode write reached monitor without permission");

	fiq_mask_a: assert property (req_i.valid && debug_state_i && HAS_SECURITY && !cur_secure
		&& fiq_mask_writable_i ##1 verdict_o.valid |-> !verdict_o.fiq_mask_we)
		else $error("fiq mask writable in nonsecure world");

	seccfg_gate_a: assert property (req_i.valid && debug_state_i && HAS_SECURITY
		&& req_i.op == dspg_pkg::OP_SECCFG_WRITE && !(cur_secure && (cur_priv
		|| (invasive_debug_enable_i && secure_privileged_debug_enable_i)))
		|=> refused_out ##0 verdict_o.undefined ##1 sticky_undef_o)
		else $error("secure configuration write not refused");

	debug_cp_a: assert property (req_i.valid && debug_state_i && req_i.op == dspg_pkg::OP_DEBUG_CP
		&& req_i.opc1 == dspg_pkg::OPC1_DEBUG && req_i.priv_ok
		|=> verdict_o.execute && !verdict_o.undefined)
		else $error("debug coprocessor transfer refused");

	lock_undef_a: assert property (req_i.valid && debug_state_i && secure_sysctrl_lock_i
		&& req_i.lock_affected && req_i.op == dspg_pkg::OP_SYSTEM_CP
		|=> verdict_o.undefined)
		else $error("locked system operation not undefined");

	world_copy_a: assert property (verdict_o.valid |-> verdict_o.bank_nonsecure
		== (HAS_SECURITY && $past(nonsecure_state_bit_i)
		&& $past(current_mode_i) != dspg_pkg::MODE_MONITOR))
		else $error("wrong world register copy selected");

	ns_reach_a: assert property (req_i.valid && debug_state_i && HAS_SECURITY
		&& req_i.op == dspg_pkg::OP_SYSTEM_CP && !cur_secure && !req_i.user_ok
		&& !req_i.coherency && req_i.reach == dspg_pkg::REACH_SECURE_ONLY
		|=> verdict_o.undefined)
		else $error("nonsecure world reached a secure-only register");

	unpriv_ldst_a: assert property (req_i.valid && debug_state_i
		&& req_i.op == dspg_pkg::OP_LOAD_STORE && req_i.unpriv_ldst
		|=> verdict_o.execute && !verdict_o.priv_access)
		else $error("unprivileged load or store made a privileged access");

	idle_quiet_a: assert property (!(req_i.valid && debug_state_i)
		|=> !verdict_o.valid && !verdict_o.execute && !verdict_o.undefined)
		else $error("verdict produced without a request");

	sequence halted_req;
		req_i.valid && debug_state_i;
	endsequence

	verdict_valid_a: assert property (halted_req |=> verdict_o.valid)
		else $error("halted request produced no verdict");

	bank_mode_a: assert property (verdict_o.valid
		|-> verdict_o.bank_mode == $past(current_mode_i))
		else $error("bank mode does not follow the current mode");

	status_accept_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_STATUS_WRITE
		&& !(HAS_SECURITY && cur_secure && cur_user
		&& !(invasive_debug_enable_i && secure_privileged_debug_enable_i)))
		|=> verdict_o.priv_bits_we)
		else $error("permitted status write was ignored");

	secpriv_roam_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_STATUS_WRITE
		&& cur_secure && cur_priv && req_i.new_mode == dspg_pkg::MODE_SYSTEM)
		|=> verdict_o.mode_we)
		else $error("secure privileged mode change refused");

	abort_mask_a: assert property (halted_req ##0 (HAS_SECURITY && !cur_secure
		&& abort_mask_writable_i) |=> !verdict_o.abort_mask_we)
		else $error("abort mask writable in nonsecure world");

	seccfg_allow_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_SECCFG_WRITE
		&& HAS_SECURITY && cur_secure && cur_priv
		&& !(secure_sysctrl_lock_i && req_i.lock_affected))
		|=> verdict_o.execute && !verdict_o.undefined)
		else $error("secure configuration write refused in secure privileged mode");

	user_cp_a: assert property (halted_req ##0 (req_i.user_ok
		&& (req_i.op == dspg_pkg::OP_DEBUG_CP || (req_i.op == dspg_pkg::OP_SYSTEM_CP
		&& !(secure_sysctrl_lock_i && req_i.lock_affected))))
		|=> verdict_o.execute)
		else $error("user-legal coprocessor access refused");

	coherency_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_SYSTEM_CP
		&& req_i.coherency && !(secure_sysctrl_lock_i && req_i.lock_affected))
		|=> verdict_o.execute)
		else $error("coherency operation refused");

	escalate_cp_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_SYSTEM_CP
		&& cur_secure && cur_priv && req_i.priv_ok && !req_i.monitor_only
		&& !(secure_sysctrl_lock_i && req_i.lock_affected))
		|=> verdict_o.execute)
		else $error("privileged coprocessor access refused in privileged mode");

	monitor_only_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_SYSTEM_CP
		&& req_i.monitor_only && !req_i.user_ok && !req_i.coherency)
		|=> verdict_o.undefined)
		else $error("monitor-only register reached in debug state");

	debug_locked_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_DEBUG_CP
		&& HAS_SECURITY && cur_secure && cur_user && !req_i.user_ok
		&& req_i.opc1 != dspg_pkg::OPC1_DEBUG
		&& !(invasive_debug_enable_i && secure_privileged_debug_enable_i))
		|=> verdict_o.undefined && verdict_o.valid)
		else $error("locked user reached a privileged debug register");

	ns_restricted_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_SYSTEM_CP
		&& HAS_SECURITY && !cur_secure && !req_i.user_ok && !req_i.coherency
		&& req_i.reach == dspg_pkg::REACH_RESTRICTED) |=> verdict_o.undefined)
		else $error("nonsecure world reached a restricted register");

	external_priv_a: assert property (halted_req ##0 (req_i.op == dspg_pkg::OP_EXTERNAL_CP)
		|=> verdict_o.execute && verdict_o.priv_access == $past(cur_priv))
		else $error("external coprocessor access used the wrong privilege");

endmodule : dspg_gate

// file: sim/dspg_debugger.sv
module dspg_debugger (
	output dspg_pkg::dspg_req_t req_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req_o = '0;

	// The caller steps just past a rising edge before presenting an instruction.
	task automatic present(input dspg_pkg::dspg_req_t r);
		req_o = r;
	endtask : present

	// A withdrawn request shows inverted fields so that stale values never match by luck.
	task automatic withdraw();
		dspg_pkg::dspg_req_t w;
		w       = ~req_o;
		w.valid = 1'b0;
		req_o   = w;
	endtask : withdraw
endmodule : dspg_debugger

// file: sim/test_debug_state_privilege_gate.sv
module test_debug_state_privilege_gate;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       halted;
		logic [4:0] mode;
		logic       ns;
		logic       dbg;
		logic       spd;
		logic       lock;
		logic       fw;
		logic       aw;
	} dspg_env_t;

	localparam logic [4:0]  USR  = dspg_pkg::MODE_USER;
	localparam logic [4:0]  SVC  = dspg_pkg::MODE_SVC;
	localparam logic [4:0]  MON  = dspg_pkg::MODE_MONITOR;
	localparam logic [4:0]  SYS  = dspg_pkg::MODE_SYSTEM;
	localparam logic [14:0] M_EU = 15'h7000;
	localparam logic [14:0] M_ED = 15'h6800;
	localparam logic [14:0] M_WR = 15'h400F;

	logic                    clk_i   = 1'b0;
	logic                    reset_i = 1'b1;
	logic                    clr     = 1'b0;
	dspg_env_t               env     = '0;
	dspg_env_t               e;
	dspg_pkg::dspg_req_t     req;
	dspg_pkg::dspg_verdict_t verdict;
	logic                    sticky;
	int                      n_errors     = 0;
	int                      total_checks = 0;
	int                      cycles       = 0;
	integer                  seed         = 32'hB2190BDA;
	logic [29:0]             exp_q[$];

	always #20 clk_i = ~clk_i;

	dspg_debugger dbg (
		.req_o(req)
	);

	dspg_gate #(.HAS_SECURITY(1'b1)) DUT (
		.clk_i                            (clk_i),
		.reset_i                          (reset_i),
		.debug_state_i                    (env.halted),
		.current_mode_i                   (env.mode),
		.nonsecure_state_bit_i            (env.ns),
		.invasive_debug_enable_i          (env.dbg),
		.secure_privileged_debug_enable_i (env.spd),
		.secure_sysctrl_lock_i            (env.lock),
		.fiq_mask_writable_i              (env.fw),
		.abort_mask_writable_i            (env.aw),
		.req_i                            (req),
		.sticky_undef_clear_i             (clr),
		.verdict_o                        (verdict),
		.sticky_undef_o                   (sticky)
	);

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	task automatic compare_verdict(input logic [14:0] got, input logic [14:0] ev, input logic [14:0] m);
		total_checks++;
		if ((got & m) !== (ev & m)) begin
			n_errors++;
			$display("MISMATCH %0t verdict got %h exp %h", $time, got & m, ev & m);
		end
	endtask : compare_verdict

	task automatic compare_bit(input logic got, input logic ev);
		total_checks++;
		if (got !== ev) begin
			n_errors++;
			$display("MISMATCH %0t flag got %h exp %h", $time, got, ev);
		end
	endtask : compare_bit

	// Every verdict pulse must match the oldest noted expectation.
	always @(negedge clk_i) begin
		if (verdict.valid !== 1'b0) begin
			if (exp_q.size() == 0) begin
				compare_verdict(verdict, 15'h0000, 15'h7FFF);
			end else begin
				compare_verdict(verdict, exp_q[0][29:15], exp_q[0][14:0]);
				exp_q.delete(0);
			end
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			wrap_up();
		end
	end

	// Flags are user_ok, priv_ok, coherency, lock_affected, ns_configured, monitor_only, unpriv.
	function automatic dspg_pkg::dspg_req_t mk(input dspg_pkg::dspg_op_t op, input logic [4:0] nm,
		input logic [2:0] o1, input dspg_pkg::dspg_reach_t rc, input logic [6:0] f);
		return '{1'b1, op, nm, f[6], f[5], o1, f[4], f[3], rc, f[2], f[1], f[0]};
	endfunction : mk

	function automatic dspg_env_t en(input logic [4:0] m, input logic ns, input logic d, input logic s);
		return '{1'b1, m, ns, d, s, 1'b0, 1'b0, 1'b0};
	endfunction : en

	function automatic logic [14:0] eud(input logic ex, input logic un, input logic di);
		return {1'b1, ex, un, di, 11'h000};
	endfunction : eud

	function automatic logic [14:0] wr(input logic mw, input logic pw, input logic f, input logic a);
		return {1'b1, 10'h000, mw, pw, f, a};
	endfunction : wr

	task automatic issue(input dspg_env_t ne, input dspg_pkg::dspg_req_t r, input logic [14:0] ev,
		input logic [14:0] m);
		@(posedge clk_i);
		#1;
		env = ne;
		dbg.present(r);
		if (ne.halted) begin
			exp_q.push_back({ev | 15'h4000, m});
		end
	endtask : issue

	task automatic settle();
		@(posedge clk_i);
		#1;
		dbg.withdraw();
		@(negedge clk_i);
	endtask : settle

	task automatic clear_sticky();
		@(posedge clk_i);
		#1;
		clr = 1'b1;
		@(posedge clk_i);
		#1;
		clr = 1'b0;
		@(negedge clk_i);
		compare_bit(sticky, 1'b0);
	endtask : clear_sticky

	initial begin : main
		logic [39:0] md;
		logic [4:0]  m;
		logic        ns;
		logic        unp;
		md = {USR, dspg_pkg::MODE_FIQ, dspg_pkg::MODE_IRQ, SVC, MON, dspg_pkg::MODE_ABORT,
			dspg_pkg::MODE_UNDEF, SYS};
		repeat (10) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		@(negedge clk_i);
		compare_verdict(verdict, 15'h0000, 15'h7FFF);
		compare_bit(sticky, 1'b0);
		issue(en(USR, 0, 0, 0), mk(dspg_pkg::OP_OTHER_PRIV, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(0, 0, 1), M_ED);
		settle();
		compare_bit(sticky, 1'b1);
		clear_sticky();
		issue(en(USR, 0, 1, 0), mk(dspg_pkg::OP_STATUS_WRITE, SVC, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(1, 0, 0) | wr(0, 0, 0, 0), M_ED | M_WR);
		issue(en(USR, 0, 1, 1), mk(dspg_pkg::OP_STATUS_WRITE, SVC, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(1, 1, 1, 1), M_WR);
		issue(en(SVC, 0, 0, 0), mk(dspg_pkg::OP_STATUS_WRITE, SYS, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(1, 1, 1, 1), M_WR);
		issue(en(SVC, 0, 0, 0), mk(dspg_pkg::OP_STATUS_WRITE, MON, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(1, 1, 1, 1), M_WR);
		issue(en(SVC, 1, 0, 0), mk(dspg_pkg::OP_STATUS_WRITE, MON, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(0, 1, 1, 1), M_WR);
		issue(en(SVC, 1, 1, 1), mk(dspg_pkg::OP_STATUS_WRITE, MON, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(1, 1, 1, 1), M_WR);
		e    = en(SVC, 1, 1, 0);
		e.fw = 1'b1;
		issue(e, mk(dspg_pkg::OP_STATUS_WRITE, SVC, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(0, 0, 0, 1), 15'h4003);
		e.fw = 1'b0;
		e.aw = 1'b1;
		issue(e, mk(dspg_pkg::OP_STATUS_WRITE, SVC, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), wr(0, 0, 1, 0), 15'h4003);
		issue(en(USR, 0, 1, 1), mk(dspg_pkg::OP_SECCFG_WRITE, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(1, 0, 0), M_EU);
		issue(en(SVC, 0, 0, 0), mk(dspg_pkg::OP_SECCFG_WRITE, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(1, 0, 0), M_EU);
		issue(en(MON, 1, 0, 0), mk(dspg_pkg::OP_SECCFG_WRITE, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(1, 0, 0), M_EU);
		issue(en(SVC, 1, 1, 1), mk(dspg_pkg::OP_SECCFG_WRITE, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(0, 1, 0), M_EU);
		issue(en(USR, 0, 1, 0), mk(dspg_pkg::OP_SECCFG_WRITE, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), eud(0, 1, 0), M_EU);
		settle();
		compare_bit(sticky, 1'b1);
		clear_sticky();
		issue(en(USR, 0, 0, 0), mk(dspg_pkg::OP_DEBUG_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h20), eud(1, 0, 0), M_EU);
		issue(en(USR, 0, 0, 0), mk(dspg_pkg::OP_DEBUG_CP, USR, 3'h1, dspg_pkg::REACH_NONSECURE, 7'h20), eud(0, 1, 0), M_EU);
		issue(en(USR, 0, 0, 0), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h40), eud(1, 0, 0), M_EU);
		issue(en(USR, 0, 0, 0), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h30), eud(1, 0, 0), M_EU);
		issue(en(SVC, 0, 0, 0), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h20), eud(1, 0, 0), M_EU);
		issue(en(SVC, 0, 0, 0), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h22), eud(0, 1, 0), M_EU);
		e      = en(SVC, 0, 0, 0);
		e.lock = 1'b1;
		issue(e, mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h68), eud(0, 1, 0), M_EU);
		issue(en(SVC, 1, 1, 1), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_SECURE_ONLY, 7'h20), eud(0, 1, 0), M_EU);
		issue(en(SVC, 1, 1, 1), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_RESTRICTED, 7'h20), eud(0, 1, 0), M_EU);
		issue(en(SVC, 1, 1, 1), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_CONFIGURABLE, 7'h24), eud(1, 0, 0), M_EU);
		issue(en(SVC, 1, 1, 1), mk(dspg_pkg::OP_SYSTEM_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h20), eud(1, 0, 0), M_EU);
		issue(en(SVC, 0, 0, 0), mk(dspg_pkg::OP_EXTERNAL_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), 15'h4400, 15'h4400);
		issue(en(USR, 1, 0, 0), mk(dspg_pkg::OP_EXTERNAL_CP, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), 15'h4000, 15'h4400);
		settle();
		clear_sticky();
		e        = en(USR, 0, 0, 0);
		e.halted = 1'b0;
		issue(e, mk(dspg_pkg::OP_OTHER_PRIV, USR, 3'h0, dspg_pkg::REACH_NONSECURE, 7'h00), 15'h0000, 15'h0000);
		settle();
		compare_bit(verdict.valid, 1'b0);
		compare_bit(sticky, 1'b0);
		for (int i = 0; i < 24; i++) begin
			m   = md[5 * ($unsigned($random(seed)) % 8) +: 5];
			ns  = $random(seed);
			unp = $random(seed);
			e   = en(m, ns, $random(seed), $random(seed));
			issue(e, mk(unp ? dspg_pkg::OP_LOAD_STORE : dspg_pkg::OP_NONPRIV, m, 3'h0, dspg_pkg::REACH_NONSECURE, {6'h00, unp}), {4'hC, !unp && m != USR, ns && m != MON, m, 4'h0}, 15'h7FF0);
		end
		settle();
		@(posedge clk_i);
		compare_bit(exp_q.size() == 0, 1'b1);
		wrap_up();
	end
endmodule : test_debug_state_privilege_gate
